// ===== pkg/dmac_map.vh
/*
 * dmac_map.vh: register indices, field positions,
 * reset values and decode constants of the double-mode alignment control block.
 * Assumes it is included by bare name from the design files; it only defines macros.
 */
`ifndef DMAC_MAP_VH
`define DMAC_MAP_VH

// ==========================================================================
// register indices (byte address is four times the index)
`define DMAC_IDX_LINK_CTRL      8'h04
`define DMAC_IDX_DBL_ALIGN      8'h67
`define DMAC_IDX_CKSUM_LEN      8'h68
`define DMAC_IDX_HILO_SEL       8'h69
`define DMAC_IDX_RSVD_TUNE_A    8'h96

// ==========================================================================
// reset values
`define DMAC_RST_LINK_CTRL      8'h00
`define DMAC_RST_DBL_ALIGN      8'hc7
`define DMAC_RST_CKSUM_LEN      8'h19
`define DMAC_RST_HILO_SEL       8'h0f
`define DMAC_RST_RSVD_TUNE_A    8'h02

// ==========================================================================
// field positions
`define DMAC_LNK_CFG_EN_BIT     0
`define DMAC_LNK_SER_EN_BIT     1
`define DMAC_LNK_PCLK_DET_BIT   2
`define DMAC_LNK_CFG_ON_BIT     3
`define DMAC_ALN_AUTO_BIT       5
`define DMAC_ALN_MODE_MSB       2
`define DMAC_ALN_MODE_LSB       0
`define DMAC_CKS_LEN_MSB        1
`define DMAC_CKS_LEN_LSB        0
`define DMAC_HL_EN_BIT          6
`define DMAC_HL_INV_BIT         5
`define DMAC_HL_SRC_MSB         4
`define DMAC_HL_SRC_LSB         0

// ==========================================================================
// alignment mode codes
`define DMAC_ALN_HS_WINDOW      3'h0
`define DMAC_ALN_FORCE_A        3'h2
`define DMAC_ALN_HS_EDGE        3'h4
`define DMAC_ALN_DE_EDGE        3'h5
`define DMAC_ALN_FORCE_B        3'h6
`define DMAC_ALN_NONE           3'h7

// ==========================================================================
// checksum length codes and their lengths in bits
`define DMAC_CKS_1BIT           2'h0
`define DMAC_CKS_5BIT           2'h1
`define DMAC_CKS_8BIT           2'h2
`define DMAC_CKS_LEN_1          4'h1
`define DMAC_CKS_LEN_5          4'h5
`define DMAC_CKS_LEN_8          4'h8
`define DMAC_CKS_LEN_BAD        4'h0

// ==========================================================================
// bus answers
`define DMAC_RESP_OKAY          2'h0
`define DMAC_RESP_SLVERR        2'h2

`endif

// ===== hw/dmac_hilo_pick.v
/*
 * dmac_hilo_pick: picks the high/low alignment signal out of the parallel
 * input word, optionally inverts it, and registers it with the word.
 * Assumes the word is already synchronised to the pixel clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dmac_hilo_pick #(
	parameter WIDTH = 16
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] word,
	input  wire [4:0]       src_sel,
	input  wire             invert,
	output reg  [WIDTH-1:0] word_q,
	output reg              hilo_q
);

	wire hilo_raw;

	// ==========================================================================
	// source select: codes with the top bit set pick nothing and read low
	assign hilo_raw = src_sel[4] ? 1'b0 : word[src_sel[3:0]];

	// word and high/low signal are sampled on the same edge
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= {WIDTH{1'b0}};
			hilo_q <= 1'b0;
		end else begin
			word_q <= word;
			hilo_q <= hilo_raw ^ invert;
		end
	end

endmodule

`default_nettype wire

// ===== hw/dmac_top.v
/*
 * dmac_top: configuration registers for double-mode word alignment,
 * configuration-link enabling and control-channel checksum length,
 * reached over AXI4-Lite. Everything runs on the pixel clock CLOCK.
 * Assumes video pins arrive asynchronously and are synchronised here.
 */
// What this block does
// - manual mode: link on if enable, serializer off
// - auto: link on if serializer on, no clock
// - code 000 aligns from sync rise while high
// - 100 realigns on sync rise, 101 on enable
// - mode resets to 111; 010/110 force align
// - enable bit gates use of high/low signal
// - invert bit flips the high/low signal
// - source code n below 16 picks parallel input n
// - source resets to input 15, used in 000
`timescale 1ns/1ps
`default_nettype none
`include "dmac_map.vh"

module dmac_top #(
	parameter WORD_W = 16
) (
	input  wire              CLOCK,
	input  wire              RST_N,
	input  wire [11:0]       S_AXI_AWADDR,
	input  wire              S_AXI_AWVALID,
	output reg               S_AXI_AWREADY,
	input  wire [31:0]       S_AXI_WDATA,
	input  wire [3:0]        S_AXI_WSTRB,
	input  wire              S_AXI_WVALID,
	output reg               S_AXI_WREADY,
	output reg  [1:0]        S_AXI_BRESP,
	output reg               S_AXI_BVALID,
	input  wire              S_AXI_BREADY,
	input  wire [11:0]       S_AXI_ARADDR,
	input  wire              S_AXI_ARVALID,
	output reg               S_AXI_ARREADY,
	output reg  [31:0]       S_AXI_RDATA,
	output reg  [1:0]        S_AXI_RRESP,
	output reg               S_AXI_RVALID,
	input  wire              S_AXI_RREADY,
	input  wire [WORD_W-1:0] PARALLEL_INPUT,
	input  wire              HORIZONTAL_SYNC,
	input  wire              DATA_ENABLE_VIDEO,
	input  wire              PIXEL_CLOCK_DETECTED,
	output reg               CONFIG_LINK_ON,
	output reg               ALIGN_STROBE,
	output reg               ALIGN_WINDOW,
	output reg               ALIGN_FORCE,
	output reg  [3:0]        CKSUM_LEN_BITS,
	output reg  [WORD_W-1:0] SAMPLED_WORD,
	output reg               SAMPLED_HILO
);

	// ==========================================================================
	// helpers

	// register select from a byte address: 0..4 mapped, 7 unmapped
	function [2:0] reg_sel;
		input [11:0] a;
		begin
			if (a[1:0] != 2'h0 || a[11:10] != 2'h0)
				reg_sel = 3'h7;
			else if (a[9:2] == `DMAC_IDX_LINK_CTRL)
				reg_sel = 3'h0;
			else if (a[9:2] == `DMAC_IDX_DBL_ALIGN)
				reg_sel = 3'h1;
			else if (a[9:2] == `DMAC_IDX_CKSUM_LEN)
				reg_sel = 3'h2;
			else if (a[9:2] == `DMAC_IDX_HILO_SEL)
				reg_sel = 3'h3;
			else if (a[9:2] == `DMAC_IDX_RSVD_TUNE_A)
				reg_sel = 3'h4;
			else
				reg_sel = 3'h7;
		end
	endfunction

	// checksum code to length in bits; forbidden code gives zero
	function [3:0] cksum_bits;
		input [1:0] code;
		begin
			case (code)
				`DMAC_CKS_1BIT: cksum_bits = `DMAC_CKS_LEN_1;
				`DMAC_CKS_5BIT: cksum_bits = `DMAC_CKS_LEN_5;
				`DMAC_CKS_8BIT: cksum_bits = `DMAC_CKS_LEN_8;
				default:        cksum_bits = `DMAC_CKS_LEN_BAD;
			endcase
		end
	endfunction

	// ==========================================================================
	// registers

	reg  [7:0]        link_ctrl_q;
	reg  [7:0]        dbl_align_config_q;
	reg  [7:0]        ctrl_checksum_length_q;
	reg  [7:0]        highlow_align_select_q;
	reg  [7:0]        reserved_tuning_a_q;
	reg               aw_have_q;
	reg  [11:0]       aw_addr_q;
	reg               w_have_q;
	reg  [7:0]        w_data_q;
	reg               w_lane0_q;
	reg  [WORD_W-1:0] par_m_q;
	reg  [WORD_W-1:0] par_s_q;
	reg  [2:0]        pin_m_q;
	reg  [2:0]        pin_s_q;
	reg               hs_prev_q;
	reg               de_prev_q;
	reg               ref_prev_q;
	reg               ser_en_hold;

	wire [2:0]        align_mode;
	wire              hilo_en;
	wire              hs_s;
	wire              de_s;
	wire              pclk_det_s;
	wire              align_ref;
	wire              do_write;
	wire [2:0]        wsel;
	wire [WORD_W-1:0] pick_word;
	wire              pick_hilo;
	reg  [7:0]        rd_byte;
	reg               strobe_d;

	assign align_mode = dbl_align_config_q[`DMAC_ALN_MODE_MSB:`DMAC_ALN_MODE_LSB];
	assign hilo_en    = highlow_align_select_q[`DMAC_HL_EN_BIT];
	assign hs_s       = pin_s_q[0];
	assign de_s       = pin_s_q[1];
	assign pclk_det_s = pin_s_q[2];
	assign do_write   = aw_have_q & w_have_q & ~S_AXI_BVALID;
	assign wsel       = reg_sel(aw_addr_q);

	// ==========================================================================
	// pin synchronisers: two flops before any logic
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			par_m_q <= {WORD_W{1'b0}};
			par_s_q <= {WORD_W{1'b0}};
			pin_m_q <= 3'h0;
			pin_s_q <= 3'h0;
		end else begin
			par_m_q <= PARALLEL_INPUT;
			par_s_q <= par_m_q;
			pin_m_q <= {PIXEL_CLOCK_DETECTED, DATA_ENABLE_VIDEO, HORIZONTAL_SYNC};
			pin_s_q <= pin_m_q;
		end
	end

	// ==========================================================================
	// write channel: address and data taken in either order
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			aw_have_q     <= 1'b0;
			aw_addr_q     <= 12'h000;
			w_have_q      <= 1'b0;
			w_data_q      <= 8'h00;
			w_lane0_q     <= 1'b0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= `DMAC_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_have_q     <= 1'b1;
				aw_addr_q     <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_have_q     <= 1'b1;
				w_data_q     <= S_AXI_WDATA[7:0];
				w_lane0_q    <= S_AXI_WSTRB[0];
				S_AXI_WREADY <= 1'b0;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= (wsel == 3'h7) ? `DMAC_RESP_SLVERR : `DMAC_RESP_OKAY;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID  <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
		end
	end

	// register storage; reserved bits are stored as written, except link control, which keeps only bits 1:0
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			link_ctrl_q            <= `DMAC_RST_LINK_CTRL;
			dbl_align_config_q     <= `DMAC_RST_DBL_ALIGN;
			ctrl_checksum_length_q <= `DMAC_RST_CKSUM_LEN;
			highlow_align_select_q <= `DMAC_RST_HILO_SEL;
			reserved_tuning_a_q    <= `DMAC_RST_RSVD_TUNE_A;
		end else if (do_write && w_lane0_q) begin
			case (wsel)
				3'h0: link_ctrl_q            <= {6'h00, w_data_q[1:0]};
				3'h1: dbl_align_config_q     <= w_data_q;
				3'h2: ctrl_checksum_length_q <= w_data_q;
				3'h3: highlow_align_select_q <= w_data_q;
				3'h4: reserved_tuning_a_q    <= w_data_q;
				default: ;
			endcase
		end
	end

	// ==========================================================================
	// read channel: data one cycle after the address is taken
	always @* begin
		case (reg_sel(S_AXI_ARADDR))
			3'h0: rd_byte = {4'h0, CONFIG_LINK_ON, pclk_det_s, link_ctrl_q[1:0]};
			3'h1: rd_byte = dbl_align_config_q;
			3'h2: rd_byte = ctrl_checksum_length_q;
			3'h3: rd_byte = highlow_align_select_q;
			3'h4: rd_byte = reserved_tuning_a_q;
			default: rd_byte = 8'h00;
		endcase
	end

	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= `DMAC_RESP_OKAY;
		end else begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID  <= 1'b1;
				S_AXI_RDATA   <= {24'h000000, rd_byte};
				S_AXI_RRESP   <= (reg_sel(S_AXI_ARADDR) == 3'h7) ?
					`DMAC_RESP_SLVERR : `DMAC_RESP_OKAY;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID  <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// configuration link enable
	always @* begin
		ser_en_hold = link_ctrl_q[`DMAC_LNK_SER_EN_BIT];
	end

	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			CONFIG_LINK_ON <= 1'b0;
			CKSUM_LEN_BITS <= `DMAC_CKS_LEN_5;
		end else begin
			if (dbl_align_config_q[`DMAC_ALN_AUTO_BIT])
				CONFIG_LINK_ON <= ser_en_hold & ~pclk_det_s;
			else
				CONFIG_LINK_ON <= link_ctrl_q[`DMAC_LNK_CFG_EN_BIT] & ~ser_en_hold;
			CKSUM_LEN_BITS <= cksum_bits(
				ctrl_checksum_length_q[`DMAC_CKS_LEN_MSB:`DMAC_CKS_LEN_LSB]);
		end
	end

	// ==========================================================================
	// high/low pick and sample
	dmac_hilo_pick #(
		.WIDTH   (WORD_W)
	) u_pick (
		.clk     (CLOCK),
		.rst_n   (RST_N),
		.word    (par_s_q),
		.src_sel (highlow_align_select_q[`DMAC_HL_SRC_MSB:`DMAC_HL_SRC_LSB]),
		.invert  (highlow_align_select_q[`DMAC_HL_INV_BIT]),
		.word_q  (pick_word),
		.hilo_q  (pick_hilo)
	);

	// reference in code 000: high/low signal when enabled, else horizontal sync
	assign align_ref = hilo_en ? pick_hilo : hs_s;

	// alignment event per mode
	always @* begin
		case (align_mode)
			`DMAC_ALN_HS_WINDOW: strobe_d = align_ref & ~ref_prev_q;
			`DMAC_ALN_HS_EDGE:   strobe_d = hs_s & ~hs_prev_q;
			`DMAC_ALN_DE_EDGE:   strobe_d = de_s & ~de_prev_q;
			default:             strobe_d = 1'b0;
		endcase
	end

	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			hs_prev_q    <= 1'b0;
			de_prev_q    <= 1'b0;
			ref_prev_q   <= 1'b0;
			ALIGN_STROBE <= 1'b0;
			ALIGN_WINDOW <= 1'b0;
			ALIGN_FORCE  <= 1'b0;
			SAMPLED_WORD <= {WORD_W{1'b0}};
			SAMPLED_HILO <= 1'b0;
		end else begin
			hs_prev_q    <= hs_s;
			de_prev_q    <= de_s;
			ref_prev_q   <= align_ref;
			ALIGN_STROBE <= strobe_d;
			// window stays open while the reference is high, closes when low
			ALIGN_WINDOW <= (align_mode == `DMAC_ALN_HS_WINDOW) & align_ref;
			ALIGN_FORCE  <= (align_mode == `DMAC_ALN_FORCE_A) |
				(align_mode == `DMAC_ALN_FORCE_B);
			SAMPLED_WORD <= pick_word;
			SAMPLED_HILO <= pick_hilo & hilo_en;
		end
	end

endmodule

`default_nettype wire

// ===== dv/dmac_props.sv
/* dmac_props: assertions on the ports of dmac_top.
   assumes it is bound into dmac_top, one clock CLOCK, reset RST_N. */
`timescale 1ns/1ps
`default_nettype none
`include "dmac_map.vh"
module dmac_props (
	input wire logic        CLOCK,
	input wire logic        RST_N,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0]  S_AXI_RRESP,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic        ALIGN_STROBE,
	input wire logic        ALIGN_WINDOW,
	input wire logic        ALIGN_FORCE,
	input wire logic [3:0]  CKSUM_LEN_BITS
);
	// ====================
	// bus and output rules
	default clocking dc @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	property p_cks; CKSUM_LEN_BITS inside {4'h0, 4'h1, 4'h5, 4'h8}; endproperty
	a_cks: assert property (p_cks) else $error("bad checksum length");
	property p_ckschg; !$stable(CKSUM_LEN_BITS) |-> $past(S_AXI_BVALID); endproperty
	a_ckschg: assert property (p_ckschg) else $error("checksum length moved without write");
	property p_stb; ALIGN_STROBE |=> !ALIGN_STROBE; endproperty
	a_stb: assert property (p_stb) else $error("strobe longer than one cycle");
	property p_frc; ALIGN_FORCE |-> !ALIGN_STROBE && !ALIGN_WINDOW; endproperty
	a_frc: assert property (p_frc) else $error("force mode with edge alignment");
	property p_rdv; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
	a_rdv: assert property (p_rdv) else $error("read answer late");
	property p_wrb; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		|-> ##[1:2] S_AXI_BVALID; endproperty
	a_wrb: assert property (p_wrb) else $error("write answer late");
	property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhi; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0; endproperty
	a_rhi: assert property (p_rhi) else $error("upper read bits set");
	property p_unm; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[1:0] != 2'h0
		|=> S_AXI_RRESP == `DMAC_RESP_SLVERR; endproperty
	a_unm: assert property (p_unm) else $error("unaligned read not refused");
	c_stb: cover property (ALIGN_STROBE);
	c_win: cover property (ALIGN_WINDOW);
	c_frc: cover property (ALIGN_FORCE);
endmodule
bind dmac_top dmac_props dmac_props_i (.CLOCK(CLOCK), .RST_N(RST_N),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.ALIGN_STROBE(ALIGN_STROBE), .ALIGN_WINDOW(ALIGN_WINDOW), .ALIGN_FORCE(ALIGN_FORCE),
	.CKSUM_LEN_BITS(CKSUM_LEN_BITS));
`default_nettype wire

// ===== dv/dmac_top_tb.sv
/* dmac_top_tb: self-checking bench for dmac_top over AXI4-Lite.
   assumes dmac_props is bound in and the map header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
module dmac_top_tb;
	logic        clk, rst_n, awv, wv, bready, arv, rready, hs, de, pclk, e;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, d, r;
	logic [15:0] pin;
	logic [15:0] ph [0:15];
	logic [3:0]  wstrb;
	wire         awrdy, wrdy, bvalid, arrdy, rvalid, link, stb, win, frc, hilo;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [3:0]  cks;
	wire  [15:0] sword;
	integer      num_errors, n_compared, seed, nstb, nwin, cyc, i, j;
	dmac_top dmac_top_i (.CLOCK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .PARALLEL_INPUT(pin), .HORIZONTAL_SYNC(hs),
		.DATA_ENABLE_VIDEO(de), .PIXEL_CLOCK_DETECTED(pclk), .CONFIG_LINK_ON(link),
		.ALIGN_STROBE(stb), .ALIGN_WINDOW(win), .ALIGN_FORCE(frc), .CKSUM_LEN_BITS(cks),
		.SAMPLED_WORD(sword), .SAMPLED_HILO(hilo));
	// ==============
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// counts alignment events and cuts a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (stb === 1'b1) nstb <= nstb + 1;
		if (win === 1'b1) nwin <= nwin + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			end_of_test;
		end
	end
	// ==============
	// shared tasks
	task end_of_test;
		if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] ev, input [31:0] g);
		n_compared = n_compared + 1;
		if (ev !== g) begin
			num_errors = num_errors + 1;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, ev, g);
		end
	endtask
	// expected checksum length in bits for a length code
	function [3:0] exp_cks(input integer c);
		exp_cks = (c == 0) ? 4'h1 : (c == 1) ? 4'h5 : (c == 2) ? 4'h8 : 4'h0;
	endfunction
	// expected link enable from {auto, clock seen, serializer on, link enable}
	function exp_link(input [3:0] k);
		exp_link = k[3] ? (k[1] & !k[2]) : (k[0] & !k[1]);
	endfunction
	// expected sampled high/low bit from a word and {enable, invert, x, source}
	function exp_hilo(input [15:0] w, input [6:0] s);
		exp_hilo = s[6] & (w[s[3:0]] ^ s[5]);
	endfunction
	// write address and data offered together, each released when taken
	task wr(input [11:0] a, input [31:0] v, input [1:0] er);
		awaddr <= a;
		wdata <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awrdy === 1'b1) awv <= 1'b0;
			if (wrdy === 1'b1) wv <= 1'b0;
		end while ((awv && awrdy !== 1'b1) || (wv && wrdy !== 1'b1));
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(er, bresp);
	endtask
	task rd(input [11:0] a, input [31:0] ev, input [1:0] er);
		araddr <= a;
		arv <= 1'b1;
		do @(posedge clk); while (arrdy !== 1'b1);
		arv <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(ev, rdata);
		chk(er, rresp);
	endtask
	// one sync pulse with pin 15, then one enable pulse
	task pulse;
		nstb = 0;
		nwin = 0;
		hs <= 1'b1;
		pin <= 16'h8000;
		repeat (6) @(posedge clk);
		hs <= 1'b0;
		pin <= 16'h0;
		de <= 1'b1;
		repeat (6) @(posedge clk);
		de <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	// ==============
	// main sequence
	initial begin
		seed = 60800;
		{num_errors, n_compared, cyc} = 96'h0;
		{awv, wv, bready, arv, rready, hs, de, pclk, rst_n} = 9'h0;
		{awaddr, araddr, wdata, pin} = 72'h0;
		wstrb = 4'hf;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(12'h010, 32'h00, 2'h0);
		rd(12'h19c, 32'hc7, 2'h0);
		rd(12'h1a0, 32'h19, 2'h0);
		rd(12'h1a4, 32'h0f, 2'h0);
		rd(12'h258, 32'h02, 2'h0);
		chk(5, cks);
		rd(12'h000, 32'h0, 2'h2);
		rd(12'h19d, 32'h0, 2'h2);
		wr(12'h25c, 32'hff, 2'h2);
		wstrb <= 4'he;
		wr(12'h1a0, 32'h1a, 2'h0);
		wstrb <= 4'hf;
		rd(12'h1a0, 32'h19, 2'h0);
		for (i = 0; i < 4; i = i + 1) begin
			wr(12'h1a0, 32'h18 | i, 2'h0);
			repeat (2) @(posedge clk);
			chk(exp_cks(i), cks);
		end
		for (i = 0; i < 16; i = i + 1) begin
			wr(12'h19c, i[3] ? 32'he7 : 32'hc7, 2'h0);
			wr(12'h010, {30'h0, i[1:0]}, 2'h0);
			pclk <= i[2];
			repeat (5) @(posedge clk);
			e = exp_link(i[3:0]);
			chk({31'h0, e}, {31'h0, link});
			rd(12'h010, {28'h0, e, i[2:0]}, 2'h0);
		end
		for (i = 0; i < 8; i = i + 1) begin
			wr(12'h19c, 32'hc0 | i, 2'h0);
			pulse;
			chk(i == 0 || i == 4 || i == 5, nstb);
			chk(i == 0 ? 6 : 0, nwin);
			chk(i == 2 || i == 6, {31'h0, frc});
		end
		wr(12'h19c, 32'hc0, 2'h0);
		wr(12'h1a4, 32'h4f, 2'h0);
		pulse;
		chk(1, nstb);
		chk(6, nwin);
		wr(12'h1a4, 32'h4e, 2'h0);
		pulse;
		chk(0, nstb);
		chk(0, nwin);
		for (i = 0; i < 12; i = i + 1) begin
			d = $random(seed);
			wr(12'h1a4, {24'h0, 1'b0, d[6:5], 1'b0, d[3:0]}, 2'h0);
			// a pin word shows on the sampled outputs at the fifth edge after it is driven
			for (j = 0; j < 13; j = j + 1) begin
				@(posedge clk);
				if (j > 4) chk(ph[j - 5], sword);
				if (j > 4) chk(exp_hilo(ph[j - 5], d[6:0]), {31'h0, hilo});
				r = $random(seed);
				ph[j] = r[15:0];
				pin <= r[15:0];
			end
		end
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(12'h1a4, 32'h0f, 2'h0);
		rd(12'h19c, 32'hc7, 2'h0);
		chk(5, cks);
		end_of_test;
	end
endmodule
`default_nettype wire
